// >>> design/dcoid_top.sv
// Overlay command engine with task-file registers on an Avalon-MM slave.
`timescale 1ns/1ps
`include "dcoid_cfg.svh"

module dcoid_top #(
    parameter int CAP_SEL = 0
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        por,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    dcoid_pkg::dcoid_state_t    state;
    dcoid_pkg::dcoid_state_t    next_state;
    dcoid_pkg::dcoid_taskfile_t tf;
    dcoid_pkg::dcoid_result_t   result;
    logic                       frozen;
    logic                       drive_pos;
    logic [7:0]                 word_idx;
    logic [7:0]                 next_idx;
    logic [15:0]                rom_word;
    logic [7:0]                 csum_sum;
    logic [7:0]                 csum_byte;
    logic [`DCOID_IRQ_W-1:0]    irq_sts;
    logic [`DCOID_IRQ_W-1:0]    irq_en;
    logic [`DCOID_IRQ_W-1:0]    irq_evt;
    logic [`DCOID_IRQ_W-1:0]    irq_clr;
    logic                       acc_done;
    logic                       wr_lo;
    logic                       cmd_wr;
    logic                       srst_wr;
    logic                       data_pop;
    logic                       xfer_start;
    logic                       ovl_abort;
    logic                       ovl_ok;
    logic                       freeze_ok;
    logic [31:0]                rd_mux;
    logic [31:0]                status_word;

    // ------------------------------------------------------------------------
    // Avalon-MM handshake
    // ------------------------------------------------------------------------
    // Every access waits exactly one cycle: read data are captured in the
    // waiting cycle, and all side effects happen at the completing edge only.
    assign acc_done = (avs_read || avs_write) && !avs_waitrequest;
    assign wr_lo    = acc_done && avs_write && avs_byteenable[0];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if (acc_done) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0;
        end
    end

    // Read data latch; unmapped and write-only offsets read zero.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_readdata <= `DCOID_RST_WORD;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    // Commands issued while busy or transferring are ignored, as is any
    // command addressed to the other drive position.
    assign cmd_wr   = wr_lo && (avs_address == `DCOID_OFS_COMMAND)
                      && (state == dcoid_pkg::DCOID_IDLE)
                      && (tf.devhead[`DCOID_DRV_BIT] == drive_pos);
    assign srst_wr  = wr_lo && (avs_address == `DCOID_OFS_DEVCTL)
                      && avs_writedata[`DCOID_SRST_BIT];
    assign data_pop = acc_done && avs_read && (avs_address == `DCOID_OFS_DATA)
                      && (state == dcoid_pkg::DCOID_XFER);
    assign irq_clr  = (wr_lo && (avs_address == `DCOID_OFS_IRQ_CLR))
                      ? avs_writedata[`DCOID_IRQ_W-1:0] : `DCOID_RST_IRQ;

    // Status word: ATA status in the low byte, error byte above, frozen flag.
    always_comb begin
        status_word                    = `DCOID_RST_WORD;
        status_word[`DCOID_ST_BSY]     = (state == dcoid_pkg::DCOID_EXEC);
        status_word[`DCOID_ST_DRDY]    = 1'b1;
        status_word[`DCOID_ST_DRQ]     = (state == dcoid_pkg::DCOID_XFER);
        status_word[`DCOID_ST_ERR]     = result.err;
        status_word[`DCOID_ER_ABRT]    = result.abrt;
        status_word[`DCOID_ST_FROZEN]  = frozen;
    end

    // Integrity byte completes the 512-byte sum to zero.
    assign csum_byte = 8'(8'h00 - csum_sum - `DCOID_SIG);

    always_comb begin
        case (avs_address)
            `DCOID_OFS_DATA: begin
                if (state != dcoid_pkg::DCOID_XFER) begin
                    rd_mux = `DCOID_RST_WORD;
                end else if (word_idx == `DCOID_LAST_WORD) begin
                    rd_mux = {16'h0000, csum_byte, rom_word[7:0]};
                end else begin
                    rd_mux = {16'h0000, rom_word};
                end
            end
            `DCOID_OFS_FEATURES: rd_mux = {24'h00_0000, tf.features};
            `DCOID_OFS_DEVHEAD:  rd_mux = {24'h00_0000, tf.devhead};
            `DCOID_OFS_COMMAND:  rd_mux = {24'h00_0000, tf.command};
            `DCOID_OFS_STATUS:   rd_mux = status_word;
            `DCOID_OFS_IRQ_STS:  rd_mux = {30'h0000_0000, irq_sts};
            `DCOID_OFS_IRQ_EN:   rd_mux = {30'h0000_0000, irq_en};
            `DCOID_OFS_CONFIG:   rd_mux = {31'h0000_0000, drive_pos};
            default:             rd_mux = `DCOID_RST_WORD;
        endcase
    end

    // ------------------------------------------------------------------------
    // Task-file registers
    // ------------------------------------------------------------------------
    // Parameter registers only load while idle so a running command keeps
    // the subcommand it was started with.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tf <= '0;
        end else if (wr_lo && (state == dcoid_pkg::DCOID_IDLE)) begin
            case (avs_address)
                `DCOID_OFS_FEATURES: tf.features <= avs_writedata[7:0];
                `DCOID_OFS_DEVHEAD:  tf.devhead  <= avs_writedata[7:0];
                `DCOID_OFS_COMMAND:  tf.command  <= avs_writedata[7:0];
                default:             tf          <= tf;
            endcase
        end
    end

    // Own drive position, set by software.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            drive_pos <= 1'b0;
        end else if (wr_lo && (avs_address == `DCOID_OFS_CONFIG)) begin
            drive_pos <= avs_writedata[0];
        end
    end

    // ------------------------------------------------------------------------
    // Subcommand decode
    // ------------------------------------------------------------------------
    // Set has no data-out path in this block and is refused; restore has no
    // reduced overlay to undo and completes without effect.
    always_comb begin
        ovl_abort  = 1'b0;
        ovl_ok     = 1'b0;
        freeze_ok  = 1'b0;
        xfer_start = 1'b0;
        if (state == dcoid_pkg::DCOID_EXEC) begin
            if ((tf.command != `DCOID_CMD_OVERLAY) || frozen) begin
                ovl_abort = 1'b1;
            end else begin
                case (tf.features)
                    `DCOID_SUB_RESTORE:  ovl_ok     = 1'b1;
                    `DCOID_SUB_FREEZE: begin
                        ovl_ok    = 1'b1;
                        freeze_ok = 1'b1;
                    end
                    `DCOID_SUB_IDENTIFY: xfer_start = 1'b1;
                    default:             ovl_abort  = 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Command engine
    // ------------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            dcoid_pkg::DCOID_IDLE: begin
                if (cmd_wr) begin
                    next_state = dcoid_pkg::DCOID_EXEC;
                end
            end
            dcoid_pkg::DCOID_EXEC: begin
                if (xfer_start) begin
                    next_state = dcoid_pkg::DCOID_XFER;
                end else begin
                    next_state = dcoid_pkg::DCOID_IDLE;
                end
            end
            dcoid_pkg::DCOID_XFER: begin
                if (data_pop && (word_idx == `DCOID_LAST_WORD)) begin
                    next_state = dcoid_pkg::DCOID_IDLE;
                end
            end
            default: next_state = dcoid_pkg::DCOID_IDLE;
        endcase
    end

    // Software reset drops any command in flight.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= dcoid_pkg::DCOID_IDLE;
        end else if (srst_wr) begin
            state <= dcoid_pkg::DCOID_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Completion result; an abort moves no data and flags both bits.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            result <= '0;
        end else if (srst_wr || cmd_wr) begin
            result <= '0;
        end else if (ovl_abort) begin
            result <= '{err: 1'b1, abrt: 1'b1};
        end
    end

    // ------------------------------------------------------------------------
    // Frozen state
    // ------------------------------------------------------------------------
    // Cleared by power-on reset alone; rst and software reset never touch it,
    // so a lock survives every reset short of a power cycle.
    always_ff @(posedge clk_sys or posedge por) begin
        if (por) begin
            frozen <= 1'b0;
        end else if (freeze_ok) begin
            frozen <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Structure transfer
    // ------------------------------------------------------------------------
    // The generator is addressed with the next index so that its registered
    // output is ready before the master can issue the following read.
    always_comb begin
        if (xfer_start) begin
            next_idx = 8'h00;
        end else if (data_pop) begin
            next_idx = 8'(word_idx + 8'h01);
        end else begin
            next_idx = word_idx;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            word_idx <= 8'h00;
        end else begin
            word_idx <= next_idx;
        end
    end

    dcoid_word_rom #(
        .CAP_SEL (CAP_SEL)
    ) u_rom (
        .clk_sys (clk_sys),
        .rst     (rst),
        .addr    (next_idx),
        .word_q  (rom_word)
    );

    // Words 0 to 254 are summed as they leave; word 255 is never added.
    dcoid_csum u_csum (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clear   (xfer_start),
        .add     (data_pop && (word_idx != `DCOID_LAST_WORD)),
        .word    (rom_word),
        .sum     (csum_sum)
    );

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    // Completion fires for non-data ends and aborts; data ready fires when the
    // identify block becomes available.
    assign irq_evt[`DCOID_IRQ_DONE] = ovl_ok || ovl_abort;
    assign irq_evt[`DCOID_IRQ_DATA] = xfer_start;

    // A new event in the clearing cycle wins, so no event is lost.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_sts <= `DCOID_RST_IRQ;
        end else begin
            irq_sts <= (irq_sts & ~irq_clr) | irq_evt;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_en <= `DCOID_RST_IRQ;
        end else if (wr_lo && (avs_address == `DCOID_OFS_IRQ_EN)) begin
            irq_en <= avs_writedata[`DCOID_IRQ_W-1:0];
        end
    end

    // Registered level output, one cycle behind the status bits.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_sts & irq_en);
        end
    end

endmodule // dcoid_top

// >>> pkg/dcoid_cfg.svh
// Offsets, field positions, reset values and fixed words of the overlay identify block.
`ifndef DCOID_CFG_SVH
`define DCOID_CFG_SVH

// --------------------
// Register byte offsets on the Avalon-MM slave
// --------------------
`define DCOID_OFS_DATA      8'h00
`define DCOID_OFS_FEATURES  8'h04
`define DCOID_OFS_DEVHEAD   8'h08
`define DCOID_OFS_COMMAND   8'h0C
`define DCOID_OFS_STATUS    8'h10
`define DCOID_OFS_DEVCTL    8'h14
`define DCOID_OFS_IRQ_STS   8'h18
`define DCOID_OFS_IRQ_CLR   8'h1C
`define DCOID_OFS_IRQ_EN    8'h20
`define DCOID_OFS_CONFIG    8'h24

// --------------------
// Field positions
// --------------------
`define DCOID_DRV_BIT       4
`define DCOID_SRST_BIT      2
`define DCOID_ST_BSY        7
`define DCOID_ST_DRDY       6
`define DCOID_ST_DRQ        3
`define DCOID_ST_ERR        0
`define DCOID_ER_ABRT       10
`define DCOID_ST_FROZEN     16
`define DCOID_IRQ_DONE      0
`define DCOID_IRQ_DATA      1
`define DCOID_IRQ_W         2

// --------------------
// Command and subcommand codes
// --------------------
`define DCOID_CMD_OVERLAY   8'hB1
`define DCOID_SUB_RESTORE   8'h00
`define DCOID_SUB_FREEZE    8'h01
`define DCOID_SUB_IDENTIFY  8'h02
`define DCOID_SUB_SET       8'h03

// --------------------
// Structure words
// --------------------
`define DCOID_W0_REV        16'h0002
`define DCOID_W1_MWDMA      16'h0007
`define DCOID_W2_UDMA       16'h003F
`define DCOID_W7_FEAT       16'h198F
`define DCOID_W_RSVD        16'h0000
`define DCOID_SIG           8'hA5
`define DCOID_LAST_WORD     8'hFF
`define DCOID_LBA_60        32'h06FC_7C7F
`define DCOID_LBA_40        32'h04A8_52FF
`define DCOID_LBA_30        32'h037E_3E3F
`define DCOID_LBA_20        32'h0254_297F

// --------------------
// Reset values
// --------------------
`define DCOID_RST_BYTE      8'h00
`define DCOID_RST_WORD      32'h0000_0000
`define DCOID_RST_IRQ       2'h0

`endif

// >>> pkg/dcoid_pkg.sv
// Types shared by the overlay identify block.
package dcoid_pkg;

    // Command engine states, Gray coded along idle, execute, transfer.
    typedef enum logic [1:0] {
        DCOID_IDLE = 2'b00,
        DCOID_EXEC = 2'b01,
        DCOID_XFER = 2'b11
    } dcoid_state_t;

    // Task-file parameters captured with a command.
    typedef struct packed {
        logic [7:0] command;
        logic [7:0] features;
        logic [7:0] devhead;
    } dcoid_taskfile_t;

    // Completion state shown in the status register.
    typedef struct packed {
        logic err;
        logic abrt;
    } dcoid_result_t;

endpackage

// >>> design/dcoid_word_rom.sv
// Word generator of the 256-word overlay capability structure, registered read.
`timescale 1ns/1ps
`include "dcoid_cfg.svh"

module dcoid_word_rom #(
    parameter int CAP_SEL = 0
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    output logic      [15:0] word_q
);

    // ------------------------------------------------------------------------
    // Capacity dependent factory maximum address
    // ------------------------------------------------------------------------
    logic [31:0] max_lba;
    logic [15:0] next_word;

    // Four capacity variants; the choice is fixed at build time.
    always_comb begin
        case (CAP_SEL)
            1:       max_lba = `DCOID_LBA_40;
            2:       max_lba = `DCOID_LBA_30;
            3:       max_lba = `DCOID_LBA_20;
            default: max_lba = `DCOID_LBA_60;
        endcase
    end

    // ------------------------------------------------------------------------
    // Word selection
    // ------------------------------------------------------------------------
    // Word 255 carries only the signature here; the checksum byte is merged by
    // the caller since it depends on the words actually delivered.
    always_comb begin
        case (addr)
            8'h00:   next_word = `DCOID_W0_REV;
            8'h01:   next_word = `DCOID_W1_MWDMA;
            8'h02:   next_word = `DCOID_W2_UDMA;
            8'h03:   next_word = max_lba[15:0];
            8'h04:   next_word = max_lba[31:16];
            8'h05:   next_word = `DCOID_W_RSVD;
            8'h06:   next_word = `DCOID_W_RSVD;
            8'h07:   next_word = `DCOID_W7_FEAT;
            8'hFF:   next_word = {8'h00, `DCOID_SIG};
            default: next_word = `DCOID_W_RSVD;
        endcase
    end

    // Registered read data keeps the output path short.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            word_q <= 16'h0000;
        end else begin
            word_q <= next_word;
        end
    end

endmodule // dcoid_word_rom

// >>> design/dcoid_csum.sv
// Modulo-256 byte accumulator for the integrity word checksum.
`timescale 1ns/1ps
`include "dcoid_cfg.svh"

module dcoid_csum (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clear,
    input  wire logic        add,
    input  wire logic [15:0] word,
    output logic      [7:0]  sum
);

    // Both bytes are added unsigned and the carry out is dropped.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sum <= `DCOID_RST_BYTE;
        end else if (clear) begin
            sum <= `DCOID_RST_BYTE;
        end else if (add) begin
            sum <= 8'(sum + word[7:0] + word[15:8]);
        end
    end

endmodule // dcoid_csum

// >>> tb/dcoid_checker.sv
// Port-level assertions for the overlay identify block.
`timescale 1ns/1ps
`include "dcoid_cfg.svh"
module dcoid_checker (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        irq
);
    // --------------------
    // Structure read tracking and properties
    // --------------------
    logic       req;
    logic       wdone;
    logic       dread;
    logic [7:0] rcnt;
    logic [7:0] acc;
    // A command write restarts the count; none may fall inside a transfer.
    assign req   = avs_read || avs_write;
    assign wdone = avs_write && !avs_waitrequest;
    assign dread = avs_read && !avs_waitrequest && avs_address == `DCOID_OFS_DATA;
    // Word index and running byte sum of the structure seen on the bus.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rcnt <= 8'h00;
            acc  <= 8'h00;
        end else if (wdone && avs_address == `DCOID_OFS_COMMAND) begin
            rcnt <= 8'h00;
            acc  <= 8'h00;
        end else if (dread) begin
            rcnt <= rcnt + 8'h01;
            acc  <= acc + avs_readdata[7:0] + avs_readdata[15:8];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_wait_low: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("Access not answered after one wait cycle.");
    a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Wait request low for more than one cycle.");
    a_wait_idle: assert property (!req |=> avs_waitrequest)
        else $error("Wait request low with no access.");
    a_rev_word: assert property (dread && rcnt == 8'h00 && avs_readdata != 0
        |-> avs_readdata == 32'h0000_0002) else $error("Revision word wrong.");
    a_mwdma_word: assert property (dread && rcnt == 8'h01
        |-> avs_readdata == 32'h0000_0007) else $error("Multiword mask wrong.");
    a_sig_byte: assert property (dread && rcnt == 8'hFF
        |-> avs_readdata[7:0] == 8'hA5) else $error("Signature byte wrong.");
    a_csum_zero: assert property (dread && rcnt == 8'hFF
        |-> 8'(acc + avs_readdata[7:0] + avs_readdata[15:8]) == 8'h00)
        else $error("Structure bytes do not sum to zero.");
    a_irq_cause: assert property ($rose(irq) |-> $past(wdone, 2) || $past(wdone, 3)
        || $past(wdone, 4)) else $error("Interrupt rose with no cause.");
    cover property (dread && rcnt == 8'hFF);
    cover property ($rose(irq));
    cover property (wdone && avs_address == `DCOID_OFS_COMMAND);
endmodule // dcoid_checker
bind dcoid_top dcoid_checker chk_u (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

// >>> tb/dcoid_host_model.sv
// Host controller model driving task-file accesses over Avalon-MM.
`timescale 1ns/1ps
`include "dcoid_cfg.svh"
module dcoid_host_model (
    input  wire logic        clk_sys,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable
);
    // --------------------
    // Bus tasks
    // --------------------
    // Idle bus at time zero; byte lanes are always all enabled.
    initial begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hF;
    end
    // Held until waitrequest is low; released lines show inverted junk.
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_address   <= ~a;
        avs_writedata <= ~d;
        @(posedge clk_sys);
    endtask
    // Command last, since its write launches execution.
    task automatic issue(input logic [7:0] f, input logic [7:0] dh, input logic [7:0] c);
        logic [31:0] q;
        access(1'b1, `DCOID_OFS_FEATURES, {24'h00_0000, f}, q);
        access(1'b1, `DCOID_OFS_DEVHEAD, {24'h00_0000, dh}, q);
        access(1'b1, `DCOID_OFS_COMMAND, {24'h00_0000, c}, q);
    endtask
endmodule // dcoid_host_model

// >>> tb/dcoid_top_bench.sv
// Self-checking bench for the overlay identify block.
`timescale 1ns/1ps
`include "dcoid_cfg.svh"
module dcoid_top_bench;
    // --------------------
    // Stimulus and checks
    // --------------------
    localparam int CAP = 2;
    logic        clk_sys;
    logic        rst;
    logic        por;
    logic [7:0]  adr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdat;
    logic [3:0]  be;
    logic [31:0] rdat;
    logic        wreq;
    logic        irq;
    logic [31:0] q;
    logic [7:0]  f;
    logic        pos;
    int          fails;
    int          n_compared;
    int          seed;
    int          cyc = 0;
    dcoid_top #(.CAP_SEL(CAP)) dut_u (.clk_sys(clk_sys), .rst(rst), .por(por),
        .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq), .irq(irq));
    dcoid_host_model host_u (.clk_sys(clk_sys), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat),
        .avs_byteenable(be));
    // Free-running 125 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Hang guard, far above the roughly 1100 cycles a run needs.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("Compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a);
        host_u.access(1'b0, a, 32'h0000_0000, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.access(1'b1, a, d, q);
    endtask
    // Don't-care device/head bits are random; the drive bit is chosen.
    task automatic cmd(input logic [7:0] fe, input logic [7:0] c, input logic d);
        logic [7:0] dh;
        dh = 8'($random(seed));
        dh[4] = d;
        host_u.issue(fe, dh, c);
    endtask
    // Hard reset, or power cycle when p is set; drive position restored.
    task automatic pulse(input logic p);
        rst <= 1'b1;
        por <= p;
        @(posedge clk_sys);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge clk_sys);
        wr(`DCOID_OFS_CONFIG, 32'(pos));
    endtask
    function automatic logic [15:0] exp_word(input int i);
        logic [31:0] lba;
        lba = CAP == 0 ? `DCOID_LBA_60 : CAP == 1 ? `DCOID_LBA_40 : `DCOID_LBA_30;
        lba = CAP == 3 ? `DCOID_LBA_20 : lba;
        case (i)
            0: return 16'h0002;
            1: return 16'h0007;
            2: return 16'h003F;
            3: return lba[15:0];
            4: return lba[31:16];
            7: return 16'h198F;
            255: return {exp_ck(), 8'hA5};
            default: return 16'h0000;
        endcase
    endfunction
    // Byte sum wraps in eight bits by construction.
    function automatic logic [7:0] exp_ck();
        logic [7:0]  s;
        logic [15:0] w;
        s = 8'hA5;
        for (int i = 0; i < 255; i++) begin
            w = exp_word(i);
            s = s + w[7:0] + w[15:8];
        end
        return -s;
    endfunction
    // Drive check, aborts, identify, freeze, resets.
    initial begin
        seed = 95684;
        fails = 0;
        n_compared = 0;
        rst = 1'b1;
        por = 1'b1;
        pos = 1'($random(seed));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge clk_sys);
        wr(`DCOID_OFS_CONFIG, 32'(pos));
        cmd(8'h00, 8'hB1, !pos);
        rd(`DCOID_OFS_IRQ_STS); check(q, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            f = (k == 0) ? 8'h00 : (k == 1) ? 8'h03 : 8'h04 | 8'($random(seed));
            wr(`DCOID_OFS_IRQ_EN, (k == 1) ? 32'h0000_0000 : 32'h0000_0003);
            cmd(f, (k == 3) ? (8'hB1 ^ (8'h01 | f)) : 8'hB1, pos);
            rd(`DCOID_OFS_DATA); check(q, 32'h0000_0000);
            rd(`DCOID_OFS_STATUS);
            check(q & 32'h0001_0409, (k == 0) ? 32'h0000_0000 : 32'h0000_0401);
            rd(`DCOID_OFS_IRQ_STS); check(q, 32'h0000_0001);
            check(32'(irq), 32'(k != 1));
            wr(`DCOID_OFS_IRQ_CLR, 32'h0000_0001);
        end
        rd(`DCOID_OFS_IRQ_STS); check(q, 32'h0000_0000);
        cmd(8'h02, 8'hB1, pos);
        rd(`DCOID_OFS_IRQ_STS); check(q, 32'h0000_0002);
        for (int i = 0; i < 256; i++) begin
            rd(`DCOID_OFS_DATA); check(q, {16'h0000, exp_word(i)});
        end
        rd(`DCOID_OFS_STATUS); check(q & 32'h0000_0008, 32'h0000_0000);
        cmd(8'h01, 8'hB1, pos);
        rd(`DCOID_OFS_STATUS); check(q & 32'h0001_0401, 32'h0001_0000);
        for (int p = 0; p < 3; p++) begin
            if (p == 1) pulse(1'b0);
            if (p == 2) wr(`DCOID_OFS_DEVCTL, 32'h0000_0004);
            if (p == 2) wr(`DCOID_OFS_DEVCTL, 32'h0000_0000);
            for (int s = 0; s < 4; s++) begin
                cmd(8'(s), 8'hB1, pos);
                rd(`DCOID_OFS_STATUS); check(q & 32'h0001_0409, 32'h0001_0401);
            end
        end
        pulse(1'b1);
        cmd(8'h00, 8'hB1, pos);
        rd(`DCOID_OFS_STATUS); check(q & 32'h0001_0401, 32'h0000_0000);
        rd(8'h80); check(q, 32'h0000_0000);
        give_verdict();
    end
endmodule // dcoid_top_bench
